// file: adc_ddr_output_formatter.sv
`timescale 1ns/1ps
//
// Contract
// - Twelve data bits leave on six pairs, two bits each; flag and clock own pairs.
// - Even bit drives in the first half of each period, odd bit in the second; with zero delay and invert clear that is clock low, then high.
// - With zero phase delay, data changes together with forwarded clock edges.
// - Driver current resets to 3.5mA; a field picks one of seven levels.
// - Enabled internal termination doubles the selected driver current.
// - Overrange flag marks out-of-scale samples and shares the data pipeline delay.
// - With zero delay and clock invert clear, the flag is presented in the clock's low phase.
// - The flag pair is driven to zero in the second half of each period.
// - A two-bit field delays the forwarded clock by 0, 45, 90, 135 degrees.
// - Delay codes: 00 none, 01 eighth, 10 quarter, 11 three eighths of period.
// - Clock invert flips clock polarity independent of delay, giving 45-degree steps.
// - Offset binary by default; two's complement setting inverts the MSB.
// - Full scale gives end codes; beyond full scale saturates with the flag set.
// - Randomizer XORs each data bit above the LSB with the LSB.
// - Randomizer leaves LSB, flag and forwarded clock unchanged.
// - Alternate polarity inverts odd data bits; even bits, flag, clock unchanged.
// - Randomizer and alternate polarity are controlled independently.
// - Test pattern enable forces flag and data to all ones, all zeros, alternating or checkerboard.
// - Alternating pattern toggles flag and data between ones and zeros per sample.
// - Checkerboard toggles between 1010101010101 and 0101010101010 per sample.
// - Test patterns override two's complement, randomizer and alternate polarity.
module adc_ddr_output_formatter
(
    // Clock, reset, enable
    input  wire logic                                i_sys_clk,
    input  wire logic                                i_srst,
    input  wire logic                                i_clk_en,
    // Sample clock pin
    input  wire logic                                i_sample_clock,
    // Converter core result
    input  wire logic [adc_fmt_pkg::WORD_W-1:0]      i_core_code,
    input  wire logic                                i_core_over,
    input  wire logic                                i_core_under,
    // Avalon-MM slave
    input  wire logic [adc_fmt_pkg::ADDR_W-1:0]      i_avs_address,
    input  wire logic                                i_avs_read,
    input  wire logic                                i_avs_write,
    input  wire logic [adc_fmt_pkg::DATA_W-1:0]      i_avs_writedata,
    input  wire logic [3:0]                          i_avs_byteenable,
    output logic      [adc_fmt_pkg::DATA_W-1:0]      o_avs_readdata,
    output logic                                     o_avs_waitrequest,
    // DDR output pairs
    output logic      [adc_fmt_pkg::PAIRS-1:0]       o_data_pair,
    output logic                                     o_overrange_flag,
    output logic                                     o_forwarded_out_clock,
    // Driver control
    output logic      [adc_fmt_pkg::CUR_W-1:0]       o_drive_current_10ua,
    output logic                                     o_termination_enable,
    output logic                                     o_duty_cycle_stabilizer_enable
);
    import adc_fmt_pkg::*;

    // ************************************************************
    // Sample clock edge detect
    // ************************************************************
    logic sample_clock_sync;
    logic sample_clock_last;
    wire  sample_boundary;

    sync_2ff u_sample_clock_sync
    (
        .i_sys_clk (i_sys_clk),
        .i_srst    (i_srst),
        .i_clk_en  (i_clk_en),
        .i_async   (i_sample_clock),
        .o_sync    (sample_clock_sync)
    );

    assign sample_boundary = sample_clock_sync && !sample_clock_last;

    always_ff @(posedge i_sys_clk)
    begin
        if (i_srst)
            sample_clock_last <= 1'b0;
        else if (i_clk_en)
            sample_clock_last <= sample_clock_sync;
    end

    // ************************************************************
    // Tick counter within one sample period
    // ************************************************************
    logic [TICK_W-1:0] tick;
    wire  [TICK_W-1:0] next_tick;

    // Holds at the last tick if the sample clock stops, so pins stay quiet
    assign next_tick = sample_boundary      ? '0 :
                       (tick == LAST_TICK)  ? tick :
                       TICK_W'(tick + 1'b1);

    always_ff @(posedge i_sys_clk)
    begin
        if (i_srst)
            tick <= LAST_TICK;
        else if (i_clk_en)
            tick <= next_tick;
    end

    // ************************************************************
    // Register file
    // ************************************************************
    logic [3:0] timing_control_reg;
    logic [3:0] output_mode_reg;
    logic [5:0] data_format_reg;

    wire        bus_request;
    wire        bus_accept;
    wire        hit_timing;
    wire        hit_output_mode;
    wire        hit_data_format;
    wire        hit_status;
    wire        write_lane0;
    wire [DATA_W-1:0] next_readdata;
    wire [DATA_W-1:0] status_word;

    assign bus_request     = i_avs_read || i_avs_write;
    assign bus_accept      = bus_request && !o_avs_waitrequest;
    assign hit_timing      = (i_avs_address == OFS_TIMING);
    assign hit_output_mode = (i_avs_address == OFS_OUTPUT_MODE);
    assign hit_data_format = (i_avs_address == OFS_DATA_FORMAT);
    assign hit_status      = (i_avs_address == OFS_STATUS);
    assign write_lane0     = i_avs_write && bus_accept && i_avs_byteenable[0];

    assign next_readdata = hit_timing      ? {28'h0000000, timing_control_reg} :
                           hit_output_mode ? {28'h0000000, output_mode_reg} :
                           hit_data_format ? {26'h0000000, data_format_reg} :
                           hit_status      ? status_word :
                           32'h00000000;

    // One wait cycle per access; write lands on the accepting edge
    always_ff @(posedge i_sys_clk)
    begin
        if (i_srst)
        begin
            o_avs_waitrequest <= 1'b1;
            o_avs_readdata    <= '0;
        end
        else if (i_clk_en)
        begin
            o_avs_waitrequest <= !(bus_request && o_avs_waitrequest);
            if (bus_request && o_avs_waitrequest)
                o_avs_readdata <= next_readdata;
        end
    end

    always_ff @(posedge i_sys_clk)
    begin
        if (i_srst)
        begin
            timing_control_reg <= TIMING_RST;
            output_mode_reg    <= OUTPUT_MODE_RST;
            data_format_reg    <= DATA_FORMAT_RST;
        end
        else if (i_clk_en && write_lane0)
        begin
            if (hit_timing)
                timing_control_reg <= i_avs_writedata[3:0];
            if (hit_output_mode)
                output_mode_reg <= i_avs_writedata[3:0];
            if (hit_data_format)
                data_format_reg <= i_avs_writedata[5:0];
        end
    end

    // ************************************************************
    // Driver current and termination
    // ************************************************************
    wire [2:0]       current_select;
    wire [CUR_W-1:0] base_current;
    wire [CUR_W-1:0] next_current;

    assign current_select = output_mode_reg[OM_CUR_LSB +: 3];
    // Unused select code falls back to the standard 3.5mA level
    assign base_current   = (current_select == CUR_SEL_4P00) ? CUR_4P00 :
                            (current_select == CUR_SEL_4P50) ? CUR_4P50 :
                            (current_select == CUR_SEL_3P00) ? CUR_3P00 :
                            (current_select == CUR_SEL_2P50) ? CUR_2P50 :
                            (current_select == CUR_SEL_2P10) ? CUR_2P10 :
                            (current_select == CUR_SEL_1P75) ? CUR_1P75 :
                            CUR_3P50;
    assign next_current   = output_mode_reg[OM_TERM_BIT] ? {base_current[CUR_W-2:0], 1'b0} : base_current;

    always_ff @(posedge i_sys_clk)
    begin
        if (i_srst)
        begin
            o_drive_current_10ua           <= CUR_3P50;
            o_termination_enable           <= 1'b0;
            o_duty_cycle_stabilizer_enable <= 1'b0;
        end
        else if (i_clk_en)
        begin
            o_drive_current_10ua           <= next_current;
            o_termination_enable           <= output_mode_reg[OM_TERM_BIT];
            o_duty_cycle_stabilizer_enable <= timing_control_reg[TIM_DCS_BIT];
        end
    end

    // ************************************************************
    // Sample capture and formatting
    // ************************************************************
    wire [WORD_W-1:0] saturated_code;
    wire              core_flag;
    wire [WORD_W-1:0] formatted_word;
    wire              formatted_flag;
    logic [WORD_W-1:0] out_word;
    logic              out_flag;
    logic              pattern_phase;
    logic [1:0]        active_phase;
    logic              active_invert;

    assign saturated_code = i_core_over  ? FULL_SCALE_POS :
                            i_core_under ? FULL_SCALE_NEG :
                            i_core_code;
    assign core_flag      = i_core_over || i_core_under;

    sample_formatter u_formatter
    (
        .i_code                (saturated_code),
        .i_flag                (core_flag),
        .i_twos                (data_format_reg[DF_TWOS_BIT]),
        .i_rand                (data_format_reg[DF_RAND_BIT]),
        .i_alt                 (data_format_reg[DF_ALT_BIT]),
        .i_test_pattern_enable (data_format_reg[DF_TEST_BIT]),
        .i_pattern             (data_format_reg[DF_PAT_LSB +: 2]),
        .i_pattern_phase       (pattern_phase),
        .o_word                (formatted_word),
        .o_flag                (formatted_flag)
    );

    // Word and clock settings are both taken only at the boundary
    always_ff @(posedge i_sys_clk)
    begin
        if (i_srst)
        begin
            out_word      <= '0;
            out_flag      <= 1'b0;
            pattern_phase <= 1'b0;
            active_phase  <= 2'h0;
            active_invert <= 1'b0;
        end
        else if (i_clk_en && sample_boundary)
        begin
            out_word      <= formatted_word;
            out_flag      <= formatted_flag;
            pattern_phase <= !pattern_phase;
            active_phase  <= timing_control_reg[TIM_PHASE_LSB +: 2];
            active_invert <= timing_control_reg[TIM_INV_BIT];
        end
    end

    // ************************************************************
    // DDR pin drive
    // ************************************************************
    wire               low_half;
    wire [TICK_W-1:0]  shifted_tick;
    wire [PAIRS-1:0]   next_pair;

    assign low_half     = !tick[TICK_W-1];
    // Each phase code step is one tick, one eighth of the period
    assign shifted_tick = TICK_W'(tick - {1'b0, active_phase});

    genvar pair;
    generate
        for (pair = 0; pair < PAIRS; pair = pair + 1)
        begin : g_pair
            assign next_pair[pair] = low_half ? out_word[2*pair] : out_word[2*pair+1];
        end
    endgenerate

    // Data and clock share one register stage so their edges align
    always_ff @(posedge i_sys_clk)
    begin
        if (i_srst)
        begin
            o_data_pair           <= '0;
            o_overrange_flag      <= 1'b0;
            o_forwarded_out_clock <= 1'b0;
        end
        else if (i_clk_en)
        begin
            o_data_pair           <= next_pair;
            o_overrange_flag      <= low_half && out_flag;
            o_forwarded_out_clock <= shifted_tick[TICK_W-1] ^ active_invert;
        end
    end

    // ************************************************************
    // Status word
    // ************************************************************
    wire delay_without_stabilizer;

    assign delay_without_stabilizer = (timing_control_reg[TIM_PHASE_LSB +: 2] != 2'h0) &&
                                      !timing_control_reg[TIM_DCS_BIT];
    assign status_word = {18'h00000, delay_without_stabilizer, out_flag, out_word};

endmodule

// file: adc_ddr_output_formatter_tb.sv
`timescale 1ns/1ps
module adc_ddr_output_formatter_tb;
    import adc_fmt_pkg::*;
    logic        i_sys_clk = 1'b0;
    logic        i_srst = 1'b1;
    logic        i_sample_clock = 1'b0;
    logic [11:0] i_core_code = 12'h000;
    logic        i_core_over = 1'b0;
    logic        i_core_under = 1'b0;
    logic [3:0]  i_avs_address = 4'h0;
    logic        i_avs_read = 1'b0;
    logic        i_avs_write = 1'b0;
    logic [31:0] i_avs_writedata = 32'h0;
    logic [3:0]  i_avs_byteenable = 4'hF;
    logic [31:0] o_avs_readdata;
    logic        o_avs_waitrequest;
    logic [5:0]  o_data_pair;
    logic        o_overrange_flag;
    logic        o_forwarded_out_clock;
    logic [9:0]  o_drive_current_10ua;
    logic        o_termination_enable;
    logic        o_duty_cycle_stabilizer_enable;
    logic [11:0] rx_word;
    logic        rx_flag;
    logic        rx_valid;
    logic [31:0] rd;
    logic [12:0] w1;
    logic [12:0] w2;
    logic [9:0]  cur_tab [8] = '{10'h15E, 10'h190, 10'h1C2, 10'h15E, 10'h12C, 10'h0FA, 10'h0D2, 10'h0AF};
    logic [5:0]  fmts [12] = '{6'h00, 6'h01, 6'h00, 6'h01, 6'h02, 6'h04, 6'h06, 6'h07, 6'h0F, 6'h1F, 6'h2F, 6'h3F};
    int          err_total = 0;
    int          cmp_count = 0;
    int          cycles = 0;
    int          n;
    adc_ddr_output_formatter i_adc_ddr_output_formatter (.i_sys_clk, .i_srst, .i_clk_en(1'b1), .i_sample_clock,
        .i_core_code, .i_core_over, .i_core_under, .i_avs_address, .i_avs_read, .i_avs_write, .i_avs_writedata,
        .i_avs_byteenable, .o_avs_readdata, .o_avs_waitrequest, .o_data_pair, .o_overrange_flag,
        .o_forwarded_out_clock, .o_drive_current_10ua, .o_termination_enable, .o_duty_cycle_stabilizer_enable);
    adc_rx_model i_adc_rx_model (.i_sys_clk, .i_data_pair(o_data_pair), .i_flag(o_overrange_flag),
        .i_fwd_clk(o_forwarded_out_clock), .o_word(rx_word), .o_flag(rx_flag), .o_valid(rx_valid));
    initial
        forever #10 i_sys_clk = ~i_sys_clk;
    initial
    begin
        #37;
        forever #80 i_sample_clock = ~i_sample_clock;
    end
    task automatic check(input logic [25:0] seen, input logic [25:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            err_total++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    always @(posedge i_sys_clk)
    begin
        cycles++;
        if (cycles == 30000)
        begin
            err_total++;
            conclude();
        end
    end
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        i_avs_address <= a;
        i_avs_write <= wr;
        i_avs_read <= !wr;
        i_avs_writedata <= d;
        @(posedge i_sys_clk iff o_avs_waitrequest === 1'b0);
        rd = o_avs_readdata;
        i_avs_write <= 1'b0;
        i_avs_read <= 1'b0;
        @(posedge i_sys_clk);
    endtask
    task automatic next_word(output logic [12:0] w);
        @(posedge i_sys_clk iff rx_valid === 1'b1);
        w = {rx_flag, rx_word};
    endtask
    function automatic logic [12:0] fmt_model(logic [11:0] c, logic ov, logic un, logic [5:0] f, logic ph);
        logic [11:0] w;
        w = ov ? 12'hFFF : (un ? 12'h000 : c);
        if (f[0]) w = w ^ 12'h800;
        if (f[1]) w = w ^ {{11{w[0]}}, 1'b0};
        if (f[2]) w = w ^ 12'hAAA;
        if (!f[3]) return {ov | un, w};
        case (f[5:4])
            2'h0: return 13'h1FFF;
            2'h1: return 13'h0000;
            2'h2: return ph ? 13'h0000 : 13'h1FFF;
            default: return ph ? 13'h0AAA : 13'h1555;
        endcase
    endfunction
    initial
    begin
        void'($urandom(32'hF98B67E3));
        repeat (6) @(posedge i_sys_clk);
        i_srst <= 1'b0;
        @(posedge i_sys_clk);
        check(o_drive_current_10ua, CUR_3P50);
        for (int a = 0; a < 4; a++)
        begin
            bus(1'b0, 4'(a * 5 - (a == 3 ? 4 : 0)), 32'h0);
            check(rd, 26'h0);
        end
        i_avs_byteenable <= 4'h0;
        bus(1'b1, OFS_TIMING, 32'hF);
        i_avs_byteenable <= 4'hF;
        bus(1'b0, OFS_TIMING, 32'h0);
        check(rd, 26'h0);
        $display("regs done");
        for (int k = 0; k < 16; k++)
        begin
            bus(1'b1, OFS_OUTPUT_MODE, 32'(k));
            repeat (3) @(posedge i_sys_clk);
            check(o_drive_current_10ua, cur_tab[k % 8] << (k / 8));
        end
        $display("current done");
        for (int k = 0; k < 12; k++)
        begin
            logic [11:0] c;
            logic [12:0] m0, m1;
            c = (k == 1) ? 12'h800 : 12'($urandom);
            i_core_code <= c;
            i_core_over <= (k == 2 || k == 9);
            i_core_under <= (k == 3);
            bus(1'b1, OFS_DATA_FORMAT, {26'h0, fmts[k]});
            repeat (3) next_word(w1);
            next_word(w2);
            m0 = fmt_model(c, k == 2 || k == 9, k == 3, fmts[k], 1'b0);
            m1 = fmt_model(c, k == 2 || k == 9, k == 3, fmts[k], 1'b1);
            if (w1 === m0) check({w1, w2}, {m0, m1});
            else check({w1, w2}, {m1, m0});
            if (!fmts[k][3])
                check(w1[11:0] ^ {fmts[k][0], 11'h0} ^ ({12{fmts[k][2]}} & 12'hAAA) ^ {{11{fmts[k][1] & w1[0]}}, 1'b0},
                    k == 3 ? 12'h000 : ((k == 2 || k == 9) ? 12'hFFF : c));
        end
        $display("format done");
        bus(1'b1, OFS_DATA_FORMAT, 32'h28);
        for (int k = 0; k < 8; k++)
        begin
            bus(1'b1, OFS_TIMING, {28'h0, 3'(k), 1'b1});
            repeat (20) @(posedge i_sys_clk);
            @(posedge i_sys_clk iff o_overrange_flag === 1'b0);
            @(posedge i_sys_clk iff o_overrange_flag === 1'b1);
            n = 0;
            while (o_forwarded_out_clock !== 1'(k / 4) && n < 8)
            begin
                @(posedge i_sys_clk);
                n++;
            end
            check(26'(n), 26'(k % 4));
        end
        $display("phase done");
        conclude();
    end
endmodule

// file: adc_fmt_pkg.sv
package adc_fmt_pkg;

    // ************************************************************
    // Widths
    // ************************************************************
    localparam int WORD_W  = 12;
    localparam int PAIRS   = 6;
    localparam int ADDR_W  = 4;
    localparam int DATA_W  = 32;
    localparam int TICK_W  = 3;
    localparam int CUR_W   = 10;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int SYS_CLK_PERIOD_NS = 20;
    localparam int SAMPLE_PERIOD_NS  = 160;
    localparam int TICKS_PER_SAMPLE  = SAMPLE_PERIOD_NS / SYS_CLK_PERIOD_NS;
    localparam logic [TICK_W-1:0] LAST_TICK = TICK_W'(TICKS_PER_SAMPLE - 1);

    // ************************************************************
    // Register byte offsets
    // ************************************************************
    localparam logic [ADDR_W-1:0] OFS_TIMING      = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_OUTPUT_MODE = 4'h4;
    localparam logic [ADDR_W-1:0] OFS_DATA_FORMAT = 4'h8;
    localparam logic [ADDR_W-1:0] OFS_STATUS      = 4'hC;

    // ************************************************************
    // Field positions and reset values
    // ************************************************************
    localparam int TIM_DCS_BIT   = 0;
    localparam int TIM_PHASE_LSB = 1;
    localparam int TIM_INV_BIT   = 3;
    localparam int OM_CUR_LSB    = 0;
    localparam int OM_TERM_BIT   = 3;
    localparam int DF_TWOS_BIT   = 0;
    localparam int DF_RAND_BIT   = 1;
    localparam int DF_ALT_BIT    = 2;
    localparam int DF_TEST_BIT   = 3;
    localparam int DF_PAT_LSB    = 4;
    localparam logic [3:0] TIMING_RST      = 4'h0;
    localparam logic [3:0] OUTPUT_MODE_RST = 4'h0;
    localparam logic [5:0] DATA_FORMAT_RST = 6'h00;

    // ************************************************************
    // Test patterns and codes
    // ************************************************************
    localparam logic [1:0] PAT_ONES        = 2'h0;
    localparam logic [1:0] PAT_ZEROS       = 2'h1;
    localparam logic [1:0] PAT_ALTERNATING = 2'h2;
    localparam logic [1:0] PAT_CHECKER     = 2'h3;
    localparam logic [WORD_W-1:0] CHECKER_A_WORD = 12'h555;
    localparam logic [WORD_W-1:0] CHECKER_B_WORD = 12'hAAA;
    localparam logic [WORD_W-1:0] ODD_BIT_MASK   = 12'hAAA;
    localparam logic [WORD_W-1:0] MSB_MASK       = 12'h800;
    localparam logic [WORD_W-1:0] FULL_SCALE_POS = 12'hFFF;
    localparam logic [WORD_W-1:0] FULL_SCALE_NEG = 12'h000;
    localparam logic [WORD_W-1:0] ALL_ONES_WORD  = 12'hFFF;
    localparam logic [WORD_W-1:0] ALL_ZEROS_WORD = 12'h000;

    // ************************************************************
    // Driver current, in units of 10 uA
    // ************************************************************
    localparam logic [2:0] CUR_SEL_3P50 = 3'h0;
    localparam logic [2:0] CUR_SEL_4P00 = 3'h1;
    localparam logic [2:0] CUR_SEL_4P50 = 3'h2;
    localparam logic [2:0] CUR_SEL_3P00 = 3'h4;
    localparam logic [2:0] CUR_SEL_2P50 = 3'h5;
    localparam logic [2:0] CUR_SEL_2P10 = 3'h6;
    localparam logic [2:0] CUR_SEL_1P75 = 3'h7;
    localparam logic [CUR_W-1:0] CUR_3P50 = 10'h15E;
    localparam logic [CUR_W-1:0] CUR_4P00 = 10'h190;
    localparam logic [CUR_W-1:0] CUR_4P50 = 10'h1C2;
    localparam logic [CUR_W-1:0] CUR_3P00 = 10'h12C;
    localparam logic [CUR_W-1:0] CUR_2P50 = 10'h0FA;
    localparam logic [CUR_W-1:0] CUR_2P10 = 10'h0D2;
    localparam logic [CUR_W-1:0] CUR_1P75 = 10'h0AF;

endpackage

// file: adc_fmt_props.sv
`timescale 1ns/1ps
module adc_fmt_props
(
    input wire logic                               i_sys_clk,
    input wire logic                               i_srst,
    input wire logic [adc_fmt_pkg::ADDR_W-1:0]     i_avs_address,
    input wire logic                               i_avs_read,
    input wire logic                               i_avs_write,
    input wire logic [adc_fmt_pkg::DATA_W-1:0]     i_avs_writedata,
    input wire logic [3:0]                         i_avs_byteenable,
    input wire logic [adc_fmt_pkg::DATA_W-1:0]     o_avs_readdata,
    input wire logic                               o_avs_waitrequest,
    input wire logic [adc_fmt_pkg::PAIRS-1:0]      o_data_pair,
    input wire logic                               o_overrange_flag,
    input wire logic [adc_fmt_pkg::CUR_W-1:0]      o_drive_current_10ua,
    input wire logic                               o_termination_enable,
    input wire logic                               o_duty_cycle_stabilizer_enable
);
    import adc_fmt_pkg::*;
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_srst);
    wire accept_wr = !o_avs_waitrequest && i_avs_write && i_avs_byteenable[0];
    chk_wait_answer: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
        else $error("late answer");
    chk_wait_pulse: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
        else $error("long answer");
    chk_reset_state: assert property ($fell(i_srst) |-> o_drive_current_10ua == CUR_3P50
        && !o_termination_enable && o_data_pair == 6'h00 && !o_overrange_flag)
        else $error("bad reset");
    chk_flag_low_half: assert property ($rose(o_overrange_flag) |-> o_overrange_flag[*4] ##1 !o_overrange_flag)
        else $error("flag width");
    chk_flag_bounded: assert property (o_overrange_flag[*4] |=> !o_overrange_flag)
        else $error("flag in high half");
    chk_dcs_copy: assert property (accept_wr && i_avs_address == OFS_TIMING
        |-> ##2 o_duty_cycle_stabilizer_enable == $past(i_avs_writedata[TIM_DCS_BIT], 2))
        else $error("stabilizer copy");
    chk_term_copy: assert property (accept_wr && i_avs_address == OFS_OUTPUT_MODE
        |-> ##2 o_termination_enable == $past(i_avs_writedata[OM_TERM_BIT], 2))
        else $error("termination copy");
    chk_unmapped_zero: assert property (!o_avs_waitrequest && i_avs_read && i_avs_address[1:0] != 2'h0
        |-> o_avs_readdata == 32'h0)
        else $error("unmapped read not zero");
endmodule
bind adc_ddr_output_formatter adc_fmt_props i_adc_fmt_props (.i_sys_clk, .i_srst, .i_avs_address, .i_avs_read,
    .i_avs_write, .i_avs_writedata, .i_avs_byteenable, .o_avs_readdata, .o_avs_waitrequest, .o_data_pair,
    .o_overrange_flag, .o_drive_current_10ua, .o_termination_enable, .o_duty_cycle_stabilizer_enable);

// file: adc_rx_model.sv
`timescale 1ns/1ps
module adc_rx_model
(
    // DDR pins in
    input  wire logic                           i_sys_clk,
    input  wire logic [adc_fmt_pkg::PAIRS-1:0]  i_data_pair,
    input  wire logic                           i_flag,
    input  wire logic                           i_fwd_clk,
    // Recovered sample
    output logic      [adc_fmt_pkg::WORD_W-1:0] o_word = '0,
    output logic                                o_flag = 1'b0,
    output logic                                o_valid = 1'b0
);
    import adc_fmt_pkg::*;
    logic             prev_clk = 1'b0;
    logic [2:0]       cnt = 3'h0;
    logic [PAIRS-1:0] even_bits = '0;
    // Mid-half sampling, clear of both edges
    always @(posedge i_sys_clk)
    begin
        o_valid <= 1'b0;
        prev_clk <= i_fwd_clk;
        cnt <= (i_fwd_clk != prev_clk) ? 3'h0 : cnt + 3'h1;
        if (cnt == 3'h1 && !i_fwd_clk)
        begin
            even_bits <= i_data_pair;
            o_flag <= i_flag;
        end
        if (cnt == 3'h1 && i_fwd_clk)
        begin
            for (int k = 0; k < PAIRS; k++)
                o_word[2*k+:2] <= {i_data_pair[k], even_bits[k]};
            o_valid <= 1'b1;
        end
    end
endmodule

// file: sample_formatter.sv
`timescale 1ns/1ps
module sample_formatter
(
    // Sample in
    input  wire logic [adc_fmt_pkg::WORD_W-1:0] i_code,
    input  wire logic                           i_flag,
    // Settings
    input  wire logic                           i_twos,
    input  wire logic                           i_rand,
    input  wire logic                           i_alt,
    input  wire logic                           i_test_pattern_enable,
    input  wire logic [1:0]                     i_pattern,
    input  wire logic                           i_pattern_phase,
    // Word out
    output logic      [adc_fmt_pkg::WORD_W-1:0] o_word,
    output logic                                o_flag
);
    import adc_fmt_pkg::*;

    wire [WORD_W-1:0] coded_word;
    wire [WORD_W-1:0] rand_word;
    wire [WORD_W-1:0] alt_word;
    wire [WORD_W-1:0] pattern_word;
    wire              pattern_flag;

    assign coded_word   = i_twos ? (i_code ^ MSB_MASK) : i_code;
    assign rand_word    = i_rand ? (coded_word ^ {{(WORD_W-1){coded_word[0]}}, 1'b0}) : coded_word;
    // Randomize first so the receiver can undo odd inversion before the XOR
    assign alt_word     = i_alt ? (rand_word ^ ODD_BIT_MASK) : rand_word;

    assign pattern_word = (i_pattern == PAT_ONES)        ? ALL_ONES_WORD :
                          (i_pattern == PAT_ZEROS)       ? ALL_ZEROS_WORD :
                          (i_pattern == PAT_ALTERNATING) ? (i_pattern_phase ? ALL_ZEROS_WORD : ALL_ONES_WORD) :
                          (i_pattern_phase ? CHECKER_B_WORD : CHECKER_A_WORD);
    assign pattern_flag = (i_pattern == PAT_ONES) ||
                          (((i_pattern == PAT_ALTERNATING) || (i_pattern == PAT_CHECKER)) && !i_pattern_phase);

    assign o_word = i_test_pattern_enable ? pattern_word : alt_word;
    assign o_flag = i_test_pattern_enable ? pattern_flag : i_flag;

endmodule

// file: sync_2ff.sv
`timescale 1ns/1ps
module sync_2ff
(
    // Clock and reset
    input  wire logic i_sys_clk,
    input  wire logic i_srst,
    input  wire logic i_clk_en,
    // Signal
    input  wire logic i_async,
    output logic      o_sync
);

    logic meta;

    always_ff @(posedge i_sys_clk)
    begin
        if (i_srst)
        begin
            meta   <= 1'b0;
            o_sync <= 1'b0;
        end
        else if (i_clk_en)
        begin
            meta   <= i_async;
            o_sync <= meta;
        end
    end

endmodule
